/* pkg/acpr_params.svh */
`ifndef ACPR_PARAMS_SVH
`define ACPR_PARAMS_SVH

// sizes
`define ACPR_N_CHAN 8
`define ACPR_N_AMP 16
`define ACPR_N_MOD 8
`define ACPR_N_GRP 8
`define ACPR_N_SA 128
`define ACPR_SA_W 7
`define ACPR_GRP_MAX 5'h10

// channel codes, lower code wins
`define ACPR_CH_PAGE 3'h0
`define ACPR_CH_LEAVE 3'h1
`define ACPR_CH_WARN 3'h2
`define ACPR_CH_AUX 3'h3
`define ACPR_CH_GEN1 3'h4
`define ACPR_CH_GEN2 3'h5
`define ACPR_CH_GEN3 3'h6
`define ACPR_CH_GEN4 3'h7
`define ACPR_PAGE_BIT 8'h01

// page signal sources
`define ACPR_SRC_NONE 2'h0
`define ACPR_SRC_LOCAL 2'h1
`define ACPR_SRC_PHONE 2'h2
`define ACPR_SRC_REMOTE 2'h3

// page commands
`define ACPR_CMD_BCAST 3'h0
`define ACPR_CMD_LEAVE 3'h1
`define ACPR_CMD_WARN 3'h2
`define ACPR_CMD_UNASGN 3'h3
`define ACPR_CMD_ZONE 3'h4

// page state codes
`define ACPR_PG_IDLE 2'h0
`define ACPR_PG_ON 2'h1
`define ACPR_PG_REL 2'h3

`endif

/* pkg/acpr_pkg.sv */
`include "acpr_params.svh"

package acpr_pkg;

  typedef enum logic [2:0] {
    ch_page = `ACPR_CH_PAGE,
    ch_leave = `ACPR_CH_LEAVE,
    ch_warn = `ACPR_CH_WARN,
    ch_aux = `ACPR_CH_AUX,
    ch_gen1 = `ACPR_CH_GEN1,
    ch_gen2 = `ACPR_CH_GEN2,
    ch_gen3 = `ACPR_CH_GEN3,
    ch_gen4 = `ACPR_CH_GEN4
  } acpr_chan_type;

  typedef enum logic [1:0] {
    src_none = `ACPR_SRC_NONE,
    src_local = `ACPR_SRC_LOCAL,
    src_phone = `ACPR_SRC_PHONE,
    src_remote = `ACPR_SRC_REMOTE
  } acpr_src_type;

  typedef enum logic [2:0] {
    cmd_bcast = `ACPR_CMD_BCAST,
    cmd_leave = `ACPR_CMD_LEAVE,
    cmd_warn = `ACPR_CMD_WARN,
    cmd_unasgn = `ACPR_CMD_UNASGN,
    cmd_zone = `ACPR_CMD_ZONE
  } acpr_cmd_type;

  typedef enum logic [1:0] {
    pg_idle = `ACPR_PG_IDLE,
    pg_on = `ACPR_PG_ON,
    pg_rel = `ACPR_PG_REL
  } acpr_pg_state_type;

endpackage : acpr_pkg

/* core/acpr_chan_pick.sv */
`timescale 1ns/100ps
`include "acpr_params.svh"

module acpr_chan_pick
  import acpr_pkg::*;
(
  // requests, bit n asks for channel n
  input logic [`ACPR_N_CHAN-1:0] req,
  // resolved choice
  output logic pick_on,
  output acpr_chan_type pick_chan
);

  logic [`ACPR_N_CHAN-1:0] req_auto;

  // page never taken from automatic requests
  assign req_auto = req & ~`ACPR_PAGE_BIT;
  assign pick_on = |req_auto;

  // lowest code wins: leave, warning, aux, general 1..4
  always_comb begin
    pick_chan = ch_page;
    for (int n = `ACPR_N_CHAN - 1; n > 0; n--) begin
      if (req_auto[n]) begin
        pick_chan = acpr_chan_type'(3'(n));
      end
    end
  end

endmodule : acpr_chan_pick

/* core/acpr_router.sv */
`timescale 1ns/100ps
`include "acpr_params.svh"


module acpr_router
  import acpr_pkg::*;
(
  // clock and reset
  input logic clk,
  input logic resetn,
  // channel requests per amplifier, bit n is channel n
  input logic [`ACPR_N_AMP-1:0][`ACPR_N_CHAN-1:0] amp_req,
  // page signal sources
  input logic local_mic_act,
  input logic ff_phone_act,
  input logic remote_mic_act,
  // page command from operator
  input logic page_act,
  input logic [2:0] page_cmd,
  input logic [`ACPR_N_AMP-1:0] zone_sel,
  // short address groups
  input logic [`ACPR_N_GRP-1:0][`ACPR_SA_W-1:0] grp_base,
  input logic [`ACPR_N_GRP-1:0][4:0] grp_len,
  input logic grp_cmd_stb,
  input logic [2:0] grp_cmd_id,
  input logic grp_cmd_on,
  // output module short addresses
  input logic [`ACPR_N_MOD-1:0][`ACPR_SA_W-1:0] mod_sa_a,
  input logic [`ACPR_N_MOD-1:0][`ACPR_SA_W-1:0] mod_sa_b,
  input logic [`ACPR_N_MOD-1:0] mod_dual,
  // amplifier routing
  output logic [`ACPR_N_AMP-1:0] amp_conn_q,
  output logic [`ACPR_N_AMP-1:0][2:0] amp_chan_q,
  // page status
  output acpr_src_type page_src_q,
  output logic page_live_q,
  // output module drives
  output logic [`ACPR_N_MOD-1:0] mod_out_a_q,
  output logic [`ACPR_N_MOD-1:0] mod_out_b_q
);

  acpr_pg_state_type pg_q;
  acpr_pg_state_type pg_d;
  acpr_src_type src_d;
  logic [`ACPR_N_AMP-1:0] page_mask_q;
  logic [`ACPR_N_AMP-1:0] mask_d;
  logic [`ACPR_N_AMP-1:0] base_on;
  acpr_chan_type base_chan [`ACPR_N_AMP];
  logic [`ACPR_N_AMP-1:0] cur_leave;
  logic [`ACPR_N_AMP-1:0] cur_warn;
  logic [`ACPR_N_AMP-1:0] page_hit;
  logic [`ACPR_N_AMP-1:0] amp_conn_d;
  logic [`ACPR_N_AMP-1:0][2:0] amp_chan_d;
  logic paging;
  logic page_start;
  logic [`ACPR_SA_W-1:0] sel_base;
  logic [4:0] sel_len;
  logic [`ACPR_N_SA-1:0] sa_member;
  logic [`ACPR_N_SA-1:0] sa_on_q;
  logic [`ACPR_N_SA-1:0] sa_on_d;
  logic [`ACPR_N_MOD-1:0] mod_a_d;
  logic [`ACPR_N_MOD-1:0] mod_b_d;

  // page source by fixed priority
  assign src_d = local_mic_act ? src_local :
                 ff_phone_act ? src_phone :
                 remote_mic_act ? src_remote : src_none;

  // page sequencing
  assign paging = (pg_q == pg_on);
  assign page_start = (pg_q == pg_idle) && page_act;

  always_comb begin
    pg_d = pg_q;
    unique case (pg_q)
      pg_idle: if (page_act) pg_d = pg_on;
      pg_on: if (!page_act) pg_d = pg_rel;
      pg_rel: pg_d = pg_idle;
      default: pg_d = pg_idle;
    endcase
  end

  // amplifiers taken by the page, fixed at page start
  assign mask_d = (page_cmd == `ACPR_CMD_BCAST) ? {`ACPR_N_AMP{1'b1}} :
                  (page_cmd == `ACPR_CMD_LEAVE) ? cur_leave :
                  (page_cmd == `ACPR_CMD_WARN) ? cur_warn :
                  (page_cmd == `ACPR_CMD_UNASGN) ? ~(cur_leave | cur_warn) :
                  (page_cmd == `ACPR_CMD_ZONE) ? zone_sel :
                  {`ACPR_N_AMP{1'b0}};

  // per amplifier resolution
  for (genvar a = 0; a < `ACPR_N_AMP; a++) begin : g_amp
    acpr_chan_pick u_pick (
      .req(amp_req[a]),
      .pick_on(base_on[a]),
      .pick_chan(base_chan[a])
    );
    assign cur_leave[a] = amp_conn_q[a] && (amp_chan_q[a] == `ACPR_CH_LEAVE);
    assign cur_warn[a] = amp_conn_q[a] && (amp_chan_q[a] == `ACPR_CH_WARN);
    assign page_hit[a] = paging && page_mask_q[a];
    // one channel per amplifier, page overrides
    assign amp_chan_d[a] = page_hit[a] ? `ACPR_CH_PAGE : base_chan[a];
    assign amp_conn_d[a] = page_hit[a] || base_on[a];

    property p_no_auto_page;
      @(posedge clk) disable iff (!resetn)
      !paging |=> !(amp_conn_q[a] && (amp_chan_q[a] == `ACPR_CH_PAGE));
    endproperty
    a_no_auto_page: assert property (p_no_auto_page)
      else $error("page routed without a page command");

    property p_leave_first;
      @(posedge clk) disable iff (!resetn)
      (amp_req[a][1] && !paging) |=> (amp_conn_q[a] && amp_chan_q[a] == `ACPR_CH_LEAVE);
    endproperty
    a_leave_first: assert property (p_leave_first)
      else $error("leave-building request lost priority");

    property p_warn_next;
      @(posedge clk) disable iff (!resetn)
      (amp_req[a][2:1] == 2'h2 && !paging) |=> (amp_chan_q[a] == `ACPR_CH_WARN);
    endproperty
    a_warn_next: assert property (p_warn_next)
      else $error("warning request lost priority");

    property p_general_order;
      @(posedge clk) disable iff (!resetn)
      (amp_req[a][7:1] == 7'h50 && !paging) |=> (amp_chan_q[a] == `ACPR_CH_GEN2);
    endproperty
    a_general_order: assert property (p_general_order)
      else $error("lower general channel did not win");

    property p_aux_over_general;
      @(posedge clk) disable iff (!resetn)
      (amp_req[a][7:1] == 7'h0C && !paging) |=> (amp_chan_q[a] == `ACPR_CH_AUX);
    endproperty
    a_aux_over_general: assert property (p_aux_over_general)
      else $error("aux channel lost to a general channel");

    sequence s_bcast_go;
      page_start && (page_cmd == `ACPR_CMD_BCAST);
    endsequence
    sequence s_held;
      page_act ##1 page_act;
    endsequence
    property p_broadcast;
      @(posedge clk) disable iff (!resetn)
      s_bcast_go ##0 s_held |=> (amp_conn_q[a] && amp_chan_q[a] == `ACPR_CH_PAGE);
    endproperty
    a_broadcast: assert property (p_broadcast)
      else $error("broadcast page missed an amplifier");

    property p_restore;
      @(posedge clk) disable iff (!resetn)
      (pg_q == pg_rel) |=> (amp_conn_q[a] == $past(base_on[a])) &&
                           (amp_chan_q[a] == $past(base_chan[a]));
    endproperty
    a_restore: assert property (p_restore)
      else $error("amplifier not restored after page");

    property p_leave_only;
      @(posedge clk) disable iff (!resetn)
      (page_start && page_cmd == `ACPR_CMD_LEAVE) |=> (page_mask_q[a] == $past(cur_leave[a]));
    endproperty
    a_leave_only: assert property (p_leave_only)
      else $error("page over leave zones took the wrong amplifier");

    property p_warn_only;
      @(posedge clk) disable iff (!resetn)
      (page_start && page_cmd == `ACPR_CMD_WARN) |=> (page_mask_q[a] == $past(cur_warn[a]));
    endproperty
    a_warn_only: assert property (p_warn_only)
      else $error("page over warning zones took the wrong amplifier");

    property p_unassigned;
      @(posedge clk) disable iff (!resetn)
      (page_start && page_cmd == `ACPR_CMD_UNASGN && (cur_leave[a] || cur_warn[a]))
        |=> !page_mask_q[a];
    endproperty
    a_unassigned: assert property (p_unassigned)
      else $error("unassigned page took a leave or warning amplifier");

    property p_zone;
      @(posedge clk) disable iff (!resetn)
      (page_start && page_cmd == `ACPR_CMD_ZONE) |=> (page_mask_q[a] == $past(zone_sel[a]));
    endproperty
    a_zone: assert property (p_zone)
      else $error("zone page mask differs from operator choice");
  end

  // short address groups
  assign sel_base = grp_base[grp_cmd_id];
  assign sel_len = (grp_len[grp_cmd_id] > `ACPR_GRP_MAX) ? `ACPR_GRP_MAX : grp_len[grp_cmd_id];

  for (genvar j = 0; j < `ACPR_N_SA; j++) begin : g_sa
    logic [`ACPR_SA_W-1:0] sa_off;
    assign sa_off = `ACPR_SA_W'(j) - sel_base;
    assign sa_member[j] = ({2'h0, sel_len} > sa_off);
    assign sa_on_d[j] = (grp_cmd_stb && sa_member[j]) ? grp_cmd_on : sa_on_q[j];

    property p_group_switch;
      @(posedge clk) disable iff (!resetn)
      (grp_cmd_stb && sa_member[j]) |=> (sa_on_q[j] == $past(grp_cmd_on));
    endproperty
    a_group_switch: assert property (p_group_switch)
      else $error("group member did not follow group command");

    property p_group_span;
      @(posedge clk) disable iff (!resetn)
      (grp_cmd_stb && !sa_member[j]) |=> $stable(sa_on_q[j]);
    endproperty
    a_group_span: assert property (p_group_span)
      else $error("address outside group was switched");
  end

  // module drives from their short addresses
  for (genvar m = 0; m < `ACPR_N_MOD; m++) begin : g_mod
    assign mod_a_d[m] = sa_on_q[mod_sa_a[m]];
    assign mod_b_d[m] = mod_dual[m] && sa_on_q[mod_sa_b[m]];
  end

  property p_src_order;
    @(posedge clk) disable iff (!resetn)
    (!local_mic_act && ff_phone_act) ##1 local_mic_act |=> (page_src_q == src_local);
  endproperty
  a_src_order: assert property (p_src_order)
    else $error("local microphone did not take the page");

  property p_phone_over_remote;
    @(posedge clk) disable iff (!resetn)
    (!local_mic_act && ff_phone_act && remote_mic_act) |=> (page_src_q == src_phone);
  endproperty
  a_phone_over_remote: assert property (p_phone_over_remote)
    else $error("remote microphone outranked phone");

  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pg_q <= pg_idle;
      page_mask_q <= '0;
      page_src_q <= src_none;
      page_live_q <= 1'b0;
    end else begin
      pg_q <= pg_d;
      page_mask_q <= page_start ? mask_d : page_mask_q;
      page_src_q <= src_d;
      page_live_q <= paging;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp_conn_q <= '0;
      amp_chan_q <= '0;
    end else begin
      amp_conn_q <= amp_conn_d;
      amp_chan_q <= amp_chan_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sa_on_q <= '0;
      mod_out_a_q <= '0;
      mod_out_b_q <= '0;
    end else begin
      sa_on_q <= sa_on_d;
      mod_out_a_q <= mod_a_d;
      mod_out_b_q <= mod_b_d;
    end
  end

endmodule : acpr_router

/* sim/acpr_panel_model.sv */
`timescale 1ns/100ps

module acpr_panel_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // operator switch
  input wire logic press,
  input wire logic [2:0] kind,
  // command to router
  output logic page_act,
  output logic [2:0] page_cmd
);
  // one press gives one held command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_act <= 1'b0;
      page_cmd <= 3'h0;
    end else begin
      page_act <= press;
      if (press && !page_act) begin
        page_cmd <= kind;
      end else if (!press) begin
        page_cmd <= ~page_cmd;
      end
    end
  end
endmodule : acpr_panel_model

/* sim/acpr_router_tb.sv */
`timescale 1ns/100ps
`include "acpr_params.svh"

module acpr_router_tb
  import acpr_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0][7:0] amp_req;
  logic local_mic_act, ff_phone_act, remote_mic_act, press, page_act, page_live_q;
  logic [2:0] kind, page_cmd, grp_cmd_id;
  logic [15:0] zone_sel, amp_conn_q, e_conn;
  logic [15:0][2:0] amp_chan_q, e_chan;
  logic [7:0][6:0] grp_base, mod_sa_a, mod_sa_b;
  logic [7:0][4:0] grp_len;
  logic grp_cmd_stb, grp_cmd_on;
  logic [7:0] mod_dual, mod_out_a_q, mod_out_b_q, ea, eb;
  acpr_src_type page_src_q;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0000002E;
  bit st [128];

  always #2 clk = ~clk;

  acpr_panel_model acpr_panel_model_i (.clk(clk), .resetn(resetn), .press(press),
    .kind(kind), .page_act(page_act), .page_cmd(page_cmd));

  acpr_router acpr_router_i (.clk(clk), .resetn(resetn), .amp_req(amp_req),
    .local_mic_act(local_mic_act), .ff_phone_act(ff_phone_act),
    .remote_mic_act(remote_mic_act), .page_act(page_act), .page_cmd(page_cmd),
    .zone_sel(zone_sel), .grp_base(grp_base), .grp_len(grp_len),
    .grp_cmd_stb(grp_cmd_stb), .grp_cmd_id(grp_cmd_id), .grp_cmd_on(grp_cmd_on),
    .mod_sa_a(mod_sa_a), .mod_sa_b(mod_sa_b), .mod_dual(mod_dual),
    .amp_conn_q(amp_conn_q), .amp_chan_q(amp_chan_q), .page_src_q(page_src_q),
    .page_live_q(page_live_q), .mod_out_a_q(mod_out_a_q), .mod_out_b_q(mod_out_b_q));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_amp();
    chk(amp_conn_q, e_conn);
    chk(amp_chan_q, e_chan);
  endtask : chk_amp

  // lowest set channel code above page wins
  task automatic model_route();
    e_conn = '0;
    e_chan = '0;
    for (int a = 0; a < 16; a++) begin
      for (int c = 7; c > 0; c--) begin
        if (amp_req[a][c]) begin
          e_conn[a] = 1'b1;
          e_chan[a] = 3'(c);
        end
      end
    end
  endtask : model_route

  // affected set fixed from shown routing
  task automatic model_page(input logic [2:0] cmd, input logic [15:0] zs);
    logic lw;
    for (int a = 0; a < 16; a++) begin
      lw = e_conn[a] && (e_chan[a] == 3'h1 || e_chan[a] == 3'h2);
      if (cmd == 3'h0 || (cmd == 3'h1 && e_conn[a] && e_chan[a] == 3'h1) ||
          (cmd == 3'h2 && e_conn[a] && e_chan[a] == 3'h2) ||
          (cmd == 3'h3 && !lw) || (cmd == 3'h4 && zs[a])) begin
        e_conn[a] = 1'b1;
        e_chan[a] = 3'h0;
      end
    end
  endtask : model_page

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    amp_req = '0;
    {local_mic_act, ff_phone_act, remote_mic_act, press, grp_cmd_stb, grp_cmd_on} = '0;
    kind = 3'h0;
    grp_cmd_id = 3'h0;
    zone_sel = '0;
    grp_base = '0;
    grp_len = '0;
    mod_sa_a = '0;
    mod_sa_b = '0;
    mod_dual = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    settle(1);
    chk({amp_conn_q, page_live_q, page_src_q, mod_out_a_q, mod_out_b_q}, 64'h0);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      for (int a = 0; a < 16; a++) begin
        amp_req[a] <= (i < 2 && a == 15) ? (i == 0 ? 8'hA0 : 8'h18) : 8'(rnd()) >> (i % 8);
      end
      settle(2);
      model_route();
      chk_amp();
    end
    $display("test routing done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {local_mic_act, ff_phone_act, remote_mic_act} <= 3'(i);
      settle(2);
      chk(page_src_q, i >= 4 ? src_local : i >= 2 ? src_phone : i ? src_remote : src_none);
      chk(page_live_q, 1'b0);
    end
    $display("test page source done");
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      for (int a = 0; a < 16; a++) amp_req[a] <= 8'(rnd()) >> (k % 3);
      zone_sel <= 16'(rnd());
      settle(2);
      model_route();
      @(posedge clk);
      press <= 1'b1;
      kind <= 3'(k);
      settle(6);
      model_page(3'(k), zone_sel);
      chk_amp();
      chk(page_live_q, 1'b1);
      @(posedge clk);
      zone_sel <= ~zone_sel;
      kind <= 3'h7;
      settle(3);
      chk_amp();
      @(posedge clk);
      press <= 1'b0;
      settle(6);
      model_route();
      chk_amp();
      chk(page_live_q, 1'b0);
    end
    $display("test page commands done");
    @(posedge clk);
    for (int g = 0; g < 8; g++) begin
      logic [6:0] b;
      b = 7'(rnd());
      grp_base[g] <= b;
      grp_len[g] <= (g == 0) ? 5'h00 : (g == 1) ? 5'h1F : 5'(rnd());
      mod_sa_a[g] <= b + 7'(rnd() % 20);
      mod_sa_b[g] <= b - 7'(rnd() % 4);
    end
    mod_dual <= 8'(rnd());
    for (int i = 0; i < 20; i++) begin
      logic [2:0] id;
      logic on;
      int l;
      id = (i < 8) ? 3'(i) : 3'(rnd());
      on = (i < 8) || (rnd() % 2);
      @(posedge clk);
      grp_cmd_stb <= 1'b1;
      grp_cmd_id <= id;
      grp_cmd_on <= on;
      @(posedge clk);
      grp_cmd_stb <= 1'b0;
      grp_cmd_id <= ~id;
      l = (grp_len[id] > 5'h10) ? 16 : grp_len[id];
      for (int a = 0; a < 128; a++) if (7'(a - grp_base[id]) < l) st[a] = on;
      for (int m = 0; m < 8; m++) begin
        ea[m] = st[mod_sa_a[m]];
        eb[m] = mod_dual[m] & st[mod_sa_b[m]];
      end
      settle(3);
      chk(mod_out_a_q, ea);
      chk(mod_out_b_q, eb);
    end
    $display("test groups done");
    wrap_up();
  end
endmodule : acpr_router_tb
